// ### rtl/status_report_pkg.sv
package status_report_pkg;

	// Standard event layout, shared by the latch and its mask
	localparam int OP_DONE_BIT   = 0;
	localparam int QUERY_ERR_BIT = 2;
	localparam int DEV_ERR_BIT   = 3;
	localparam int EXEC_ERR_BIT  = 4;
	localparam int CMD_ERR_BIT   = 5;
	localparam int POWER_ON_BIT  = 7;
	localparam logic [7:0] STD_EVENT_USED = 8'hBD;

	// Status byte layout
	localparam int QSB_BIT = 3;
	localparam int MSG_AVAIL_BIT = 4;
	localparam int ESB_BIT = 5;
	localparam int REQ_SVC_BIT = 6;
	localparam logic [7:0] SERVICE_MASK_USED = 8'hBE;

	// Values after reset
	localparam logic [7:0]  STD_EVENT_RESET     = 8'h80;
	localparam logic [7:0]  STD_MASK_RESET      = 8'h00;
	localparam logic [7:0]  SERVICE_MASK_RESET  = 8'h00;
	localparam logic [15:0] COND_EVENT_RESET    = 16'h0000;
	localparam logic [15:0] COND_MASK_RESET     = 16'h0000;

	// Register access commands, as decoded by the message parser
	typedef enum logic [3:0] {
		CMD_NONE            = 4'h0,
		CMD_READ_STATUS     = 4'h1,
		CMD_SERIAL_POLL     = 4'h2,
		CMD_READ_EVENT      = 4'h3,
		CMD_READ_EVENT_MASK = 4'h4,
		CMD_WRITE_EVENT_MASK= 4'h5,
		CMD_READ_SVC_MASK   = 4'h6,
		CMD_WRITE_SVC_MASK  = 4'h7,
		CMD_READ_COND       = 4'h8,
		CMD_READ_COND_MASK  = 4'h9,
		CMD_WRITE_COND_MASK = 4'hA,
		CMD_CLEAR_STATUS    = 4'hB
	} cmd_code_t;

	typedef struct packed {
		logic      valid;
		cmd_code_t code;
		logic [15:0] data;
	} cmd_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} rsp_t;

	// Event sources, one-cycle pulses from the command engine
	typedef struct packed {
		logic op_done_cmd;   // Operation-complete command received
		logic engine_idle;   // All earlier commands done, ready for input
		logic host_read;     // Host tries to read the output buffer
		logic output_pending;// A response is still being built
		logic line_start;    // New command line arrives
		logic buffers_full;  // Input and output buffers both full
		logic cal_bad_input;
		logic serial_overflow;
		logic exec_error;
		logic parse_error;
		logic response_loaded; // Query response entered output buffer
		logic terminator_sent; // Output terminator went to the host
		logic local_request;   // Service requested from the front panel
	} events_t;

endpackage

// ### rtl/standard_event_status_reporting.sv
`timescale 1ns/1ps
// How it works
// - Requesting service sets status bit 6 and pulls the request line.
// - A serial poll returns the live status byte to the host.
// - Status byte built from masks, event latches and output buffer state.
// - Event bits latch and stay set until read or cleared.
// - Mask bit one lets its event into the summary, zero blocks it.
// - An enabled event bit going 0 to 1 sets the event summary.
// - Reading the event latch or clear-status drops the event summary.
// - Event layout: bits 0,2,3,4,5,7 used; bits 1 and 6 read zero.
// - Operation complete sets once earlier commands finish and input is ready.
// - Query error on empty read, unread reply overrun, or both buffers full.
// - Device error on bad calibration input or serial input overflow.
// - Execution error when a parsed command cannot be carried out.
// - Command error when a command cannot be understood.
// - Power-on flag set after power returns, until read or cleared.
// - Request bit sets on new summary or local request; poll clears it.
// - Message-available sets on loaded reply, clears after terminator sent.
// - Enabled condition event rising sets the condition summary bit.
module standard_event_status_reporting
	import status_report_pkg::*;
#(
	parameter int COND_WIDTH = 16
) (
	input  wire logic                     clk_sys_i,
	input  wire logic                     rst_i,
	input  wire status_report_pkg::cmd_t  cmd_i,
	input  wire status_report_pkg::events_t evt_i,
	input  wire logic [COND_WIDTH-1:0]    cond_event_i,
	input  wire logic                     srq_i,
	output logic                          srq_o,
	output logic                          srq_oe_o,
	output logic                          srq_line_low_o,
	output status_report_pkg::rsp_t       rsp_o,
	output logic [7:0]                    status_byte_o
);
	import status_report_pkg::*;

	logic [7:0]            standard_event_latch;
	logic [7:0]            standard_event_mask;
	logic [7:0]            service_enable_mask;
	logic [COND_WIDTH-1:0] cond_latch;
	logic [COND_WIDTH-1:0] cond_mask;
	logic [7:0]            enabled_prev;
	logic [COND_WIDTH-1:0] cond_enabled_prev;
	logic                  event_summary;
	logic                  cond_summary;
	logic                  message_available_flag;
	logic                  request_service_flag;
	logic                  master_summary_prev;
	logic                  op_done_armed;
	logic                  srq_meta;
	logic                  srq_sync;

	logic [7:0]            next_event_set;
	logic                  read_event;
	logic                  read_cond;
	logic                  clear_status;
	logic                  master_summary_flag;
	logic [7:0]            status_byte;

	// Status byte with bit 6 left open; caller picks summary or request
	function automatic logic [7:0] pack_status(input logic qsb, input logic msg,
			input logic esb, input logic bit6);
		logic [7:0] b;
		b = 8'h00;
		b[QSB_BIT] = qsb;
		b[MSG_AVAIL_BIT] = msg;
		b[ESB_BIT] = esb;
		b[REQ_SVC_BIT] = bit6;
		return b;
	endfunction

	// Command decode strobes
	assign read_event   = cmd_i.valid && (cmd_i.code == CMD_READ_EVENT);
	assign read_cond    = cmd_i.valid && (cmd_i.code == CMD_READ_COND);
	assign clear_status = cmd_i.valid && (cmd_i.code == CMD_CLEAR_STATUS);

	// Collect this cycle's event causes into the shared layout
	always_comb begin
		next_event_set = 8'h00;
		next_event_set[OP_DONE_BIT] = op_done_armed && evt_i.engine_idle;
		next_event_set[QUERY_ERR_BIT] = (evt_i.host_read && !message_available_flag
				&& !evt_i.output_pending)
			|| (evt_i.line_start && message_available_flag)
			|| evt_i.buffers_full;
		next_event_set[DEV_ERR_BIT] = evt_i.cal_bad_input || evt_i.serial_overflow;
		next_event_set[EXEC_ERR_BIT] = evt_i.exec_error;
		next_event_set[CMD_ERR_BIT] = evt_i.parse_error;
	end

	assign master_summary_flag = |(pack_status(cond_summary, message_available_flag,
			event_summary, 1'b0) & service_enable_mask & SERVICE_MASK_USED);
	// Query view: bit 6 is the live summary, so a query never clears anything
	assign status_byte = pack_status(cond_summary, message_available_flag,
			event_summary, master_summary_flag);

	// Operation-complete request waits until the engine drains
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			op_done_armed <= 1'b0;
		end else if (evt_i.op_done_cmd) begin
			op_done_armed <= 1'b1;
		end else if (evt_i.engine_idle) begin
			op_done_armed <= 1'b0;
		end
	end

	// Event latch; a new event in the reading cycle survives the clear
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			// power-on flag set by power-on reset
			standard_event_latch <= STD_EVENT_RESET;
		end else if (read_event || clear_status) begin
			standard_event_latch <= next_event_set & STD_EVENT_USED;
		end else begin
			standard_event_latch <= (standard_event_latch | next_event_set)
				& STD_EVENT_USED;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			standard_event_mask <= STD_MASK_RESET;
			service_enable_mask <= SERVICE_MASK_RESET;
			cond_mask           <= COND_WIDTH'(COND_MASK_RESET);
		end else if (cmd_i.valid) begin
			if (cmd_i.code == CMD_WRITE_EVENT_MASK) begin
				standard_event_mask <= cmd_i.data[7:0] & STD_EVENT_USED;
			end else if (cmd_i.code == CMD_WRITE_SVC_MASK) begin
				// Bit 6 cannot enable itself
				service_enable_mask <= cmd_i.data[7:0] & SERVICE_MASK_USED;
			end else if (cmd_i.code == CMD_WRITE_COND_MASK) begin
				cond_mask <= cmd_i.data[COND_WIDTH-1:0];
			end
		end
	end

	// Condition event latch, same sticky and read-clear behaviour
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cond_latch <= COND_WIDTH'(COND_EVENT_RESET);
		end else if (read_cond || clear_status) begin
			cond_latch <= cond_event_i;
		end else begin
			cond_latch <= cond_latch | cond_event_i;
		end
	end

	// Remember enabled bits to find 0-to-1 changes
	// A mask write that uncovers an old event counts as a change as well
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			enabled_prev      <= 8'h00;
			cond_enabled_prev <= COND_WIDTH'(COND_EVENT_RESET);
		end else begin
			enabled_prev      <= standard_event_latch & standard_event_mask;
			cond_enabled_prev <= cond_latch & cond_mask;
		end
	end

	// Event summary: a fresh rising edge beats a clear in the same cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			event_summary <= 1'b0;
		end else if (|(standard_event_latch & standard_event_mask & ~enabled_prev)) begin
			event_summary <= 1'b1;
		end else if (read_event || clear_status) begin
			event_summary <= 1'b0;
		end
	end

	// Condition summary
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cond_summary <= 1'b0;
		end else if (|(cond_latch & cond_mask & ~cond_enabled_prev)) begin
			cond_summary <= 1'b1;
		end else if (read_cond || clear_status) begin
			cond_summary <= 1'b0;
		end
	end

	// Message available follows the output buffer
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			message_available_flag <= 1'b0;
		end else if (evt_i.response_loaded) begin
			// set on load, wins over terminator
			message_available_flag <= 1'b1;
		end else if (evt_i.terminator_sent) begin
			message_available_flag <= 1'b0;
		end
	end

	// Request service on a rising summary; the level alone would re-raise after every poll
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			master_summary_prev  <= 1'b0;
			request_service_flag <= 1'b0;
		end else begin
			master_summary_prev <= master_summary_flag;
			if ((master_summary_flag && !master_summary_prev) || evt_i.local_request) begin
				request_service_flag <= 1'b1;
			end else if (cmd_i.valid && (cmd_i.code == CMD_SERIAL_POLL)) begin
				request_service_flag <= 1'b0;
			end
		end
	end

	// Open-drain request line, pulled low while requesting
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			srq_o    <= 1'b1;
			srq_oe_o <= 1'b1;
		end else begin
			srq_o    <= !request_service_flag;
			srq_oe_o <= !request_service_flag;
		end
	end

	// Bus level seen on the request line, two-stage synchroniser
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			srq_meta       <= 1'b1;
			srq_sync       <= 1'b1;
			srq_line_low_o <= 1'b0;
		end else begin
			srq_meta       <= srq_i;
			srq_sync       <= srq_meta;
			srq_line_low_o <= !srq_sync;
		end
	end

	// Visible status byte with bit 6 as request service
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			status_byte_o <= 8'h00;
		end else begin
			status_byte_o <= pack_status(cond_summary, message_available_flag,
				event_summary, request_service_flag);
		end
	end

	// Read answers, one cycle after the command
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rsp_o <= '0;
		end else begin
			rsp_o.valid <= 1'b0;
			rsp_o.data  <= 16'h0000;
			if (cmd_i.valid) begin
				if (cmd_i.code == CMD_READ_STATUS) begin
					// Query leaves the byte untouched, bit 6 as summary
					rsp_o.valid <= 1'b1;
					rsp_o.data  <= {8'h00, status_byte};
				end else if (cmd_i.code == CMD_SERIAL_POLL) begin
					rsp_o.valid <= 1'b1;
					rsp_o.data  <= {8'h00, pack_status(cond_summary,
						message_available_flag, event_summary, request_service_flag)};
				end else if (cmd_i.code == CMD_READ_EVENT) begin
					rsp_o.valid <= 1'b1;
					rsp_o.data  <= {8'h00, standard_event_latch};
				end else if (cmd_i.code == CMD_READ_EVENT_MASK) begin
					rsp_o.valid <= 1'b1;
					rsp_o.data  <= {8'h00, standard_event_mask};
				end else if (cmd_i.code == CMD_READ_SVC_MASK) begin
					rsp_o.valid <= 1'b1;
					rsp_o.data  <= {8'h00, service_enable_mask};
				end else if (cmd_i.code == CMD_READ_COND) begin
					rsp_o.valid <= 1'b1;
					rsp_o.data  <= 16'(cond_latch);
				end else if (cmd_i.code == CMD_READ_COND_MASK) begin
					rsp_o.valid <= 1'b1;
					rsp_o.data  <= 16'(cond_mask);
				end
			end
		end
	end

endmodule // standard_event_status_reporting

// ### tb/status_report_props.sv
`timescale 1ns/1ps
// Port-level checks; one clock domain, so default clocking is used
module status_report_props
	import status_report_pkg::*;
(
	input wire logic                     clk_sys_i,
	input wire logic                     rst_i,
	input wire status_report_pkg::cmd_t  cmd_i,
	input wire status_report_pkg::events_t evt_i,
	input wire logic                     srq_o,
	input wire logic                     srq_oe_o,
	input wire status_report_pkg::rsp_t  rsp_o,
	input wire logic [7:0]               status_byte_o
);
	import status_report_pkg::*;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic rd_cmd;
	// Codes that owe the host an answer
	assign rd_cmd = cmd_i.valid && (cmd_i.code inside {CMD_READ_STATUS, CMD_SERIAL_POLL,
		CMD_READ_EVENT, CMD_READ_EVENT_MASK, CMD_READ_SVC_MASK, CMD_READ_COND,
		CMD_READ_COND_MASK});
	// No event and no event mask write, so nothing can re-raise the summary
	sequence s_calm;
		evt_i == '0 && !(cmd_i.valid && cmd_i.code == CMD_WRITE_EVENT_MASK);
	endsequence
	sequence s_drop;
		cmd_i.valid && (cmd_i.code inside {CMD_CLEAR_STATUS, CMD_READ_EVENT});
	endsequence
	a_read_answered: assert property (rd_cmd |=> rsp_o.valid)
		else $error("read without answer");
	a_write_silent: assert property (!rd_cmd |=> !rsp_o.valid)
		else $error("answer without read");
	a_summary_drop: assert property (s_calm ##1 s_calm ##1 (s_calm and s_drop)
		|=> ##1 !status_byte_o[ESB_BIT]) else $error("event summary kept");
	a_byte_spare: assert property (status_byte_o[2:0] == 3'h0 && !status_byte_o[7])
		else $error("spare status bit set");
	a_event_layout: assert property (cmd_i.valid &&
		(cmd_i.code inside {CMD_READ_EVENT, CMD_READ_EVENT_MASK})
		|=> rsp_o.data[1] == 1'b0 && rsp_o.data[6] == 1'b0 && rsp_o.data[15:8] == 8'h00)
		else $error("spare event bit set");
	a_drive_low: assert property (!srq_oe_o |-> !srq_o)
		else $error("request line driven high");
	a_request_out: assert property ($rose(status_byte_o[REQ_SVC_BIT]) |-> !srq_oe_o)
		else $error("request line not pulled");
	a_request_held: assert property (!srq_oe_o |-> status_byte_o[REQ_SVC_BIT])
		else $error("request line without request");
endmodule // status_report_props

// ### tb/srq_bus_model.sv
`timescale 1ns/1ps
// Shared request wire with a pull-up; any device may pull it low
module srq_bus_model (
	input  wire logic drv_i,
	input  wire logic drv_oe_n_i,
	input  wire logic other_req_i,
	output logic      wire_o
);
	// open-drain wire, polled by the host
	assign wire_o = !((!drv_oe_n_i && !drv_i) || other_req_i);
endmodule // srq_bus_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import status_report_pkg::*;
	logic        clk_sys_i, rst_i, other_req, srq_i, srq_o, srq_oe_o, srq_line_low_o;
	cmd_t        cmd_i;
	events_t     evt_i;
	logic [15:0] cond_event_i;
	rsp_t        rsp_o;
	logic [7:0]  status_byte_o;
	int          error_cnt, checks_done;
	// Error sources and the latch bit each one must land on
	logic [12:0] ev [6] = '{13'h0400, 13'h0080, 13'h0040, 13'h0020, 13'h0010, 13'h0008};
	logic [7:0]  eb [6] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h10, 8'h20};
	standard_event_status_reporting dut (.clk_sys_i, .rst_i, .cmd_i, .evt_i, .cond_event_i,
		.srq_i, .srq_o, .srq_oe_o, .srq_line_low_o, .rsp_o, .status_byte_o);
	srq_bus_model bus (.drv_i(srq_o), .drv_oe_n_i(srq_oe_o), .other_req_i(other_req),
		.wire_o(srq_i));
	task automatic check(input string nm, input logic [16:0] seen, input logic [16:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One command, held for exactly one taking edge
	task automatic send(input cmd_code_t c, input logic [15:0] d);
		@(posedge clk_sys_i);
		cmd_i <= '{1'b1, c, d};
		@(posedge clk_sys_i);
		cmd_i <= '0;
		#1;
	endtask
	task automatic rd(input cmd_code_t c, input logic [15:0] e);
		send(c, 16'h0000);
		check(c.name(), {rsp_o.valid, rsp_o.data}, {1'b1, e});
	endtask
	// Four edges cover latch, summary, request and status byte latency
	task automatic pulse(input logic [12:0] e);
		@(posedge clk_sys_i);
		evt_i <= e;
		@(posedge clk_sys_i);
		evt_i <= '0;
		repeat (4) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic sb(input logic [7:0] e);
		check("status_byte", {9'h000, status_byte_o}, {9'h000, e});
	endtask
	task results;
		if (error_cnt == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	// Hang guard: all waits are fixed, this only catches a stuck run
	initial begin
		#200000;
		error_cnt++;
		results();
	end
	initial begin
		rst_i = 1'b1;
		other_req = 1'b0;
		cmd_i = '0;
		evt_i = '0;
		cond_event_i = 16'h0000;
		error_cnt = 0;
		checks_done = 0;
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		rd(CMD_READ_EVENT, 16'h0080);
		rd(CMD_READ_EVENT, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			pulse(ev[i]);
			rd(CMD_READ_EVENT, {8'h00, eb[i]});
		end
		// Masked event stays out of the summary until enabled
		pulse(13'h0010);
		sb(8'h00);
		send(CMD_WRITE_EVENT_MASK, 16'h00FF);
		rd(CMD_READ_EVENT_MASK, 16'h00BD);
		send(CMD_WRITE_SVC_MASK, 16'h00FF);
		rd(CMD_READ_SVC_MASK, 16'h00BE);
		repeat (4) @(posedge clk_sys_i);
		#1;
		sb(8'h60);
		rd(CMD_READ_STATUS, 16'h0060);
		rd(CMD_SERIAL_POLL, 16'h0060);
		@(posedge clk_sys_i);
		#1;
		sb(8'h20);
		rd(CMD_READ_EVENT, 16'h0010);
		@(posedge clk_sys_i);
		#1;
		sb(8'h00);
		// Clear-status drops the summary but keeps request and masks
		pulse(13'h0010);
		sb(8'h60);
		send(CMD_CLEAR_STATUS, 16'h0000);
		@(posedge clk_sys_i);
		#1;
		sb(8'h40);
		rd(CMD_READ_EVENT_MASK, 16'h00BD);
		rd(CMD_SERIAL_POLL, 16'h0040);
		rd(CMD_READ_EVENT, 16'h0000);
		// Completion waits for the engine to go idle
		pulse(13'h1000);
		rd(CMD_READ_EVENT, 16'h0000);
		pulse(13'h0800);
		rd(CMD_READ_EVENT, 16'h0001);
		rd(CMD_SERIAL_POLL, 16'h0040);
		// Reply loaded, new line before reading it, then terminator
		pulse(13'h0004);
		sb(8'h50);
		pulse(13'h0100);
		sb(8'h70);
		pulse(13'h0002);
		sb(8'h60);
		rd(CMD_READ_EVENT, 16'h0004);
		rd(CMD_SERIAL_POLL, 16'h0040);
		pulse(13'h0001);
		sb(8'h40);
		repeat (3) @(posedge clk_sys_i);
		#1;
		check("srq_line_low", {16'h0000, srq_line_low_o}, 17'h00001);
		send(CMD_WRITE_COND_MASK, 16'h0001);
		@(posedge clk_sys_i);
		cond_event_i <= 16'h0001;
		@(posedge clk_sys_i);
		cond_event_i <= 16'h0000;
		repeat (4) @(posedge clk_sys_i);
		#1;
		sb(8'h48);
		rd(CMD_READ_COND_MASK, 16'h0001);
		rd(CMD_READ_COND, 16'h0001);
		// Poll releases the wire; then another device pulls it
		rd(CMD_SERIAL_POLL, 16'h0040);
		repeat (5) @(posedge clk_sys_i);
		other_req <= 1'b1;
		#1;
		sb(8'h00);
		check("srq_line_low", {16'h0000, srq_line_low_o}, 17'h00000);
		repeat (4) @(posedge clk_sys_i);
		#1;
		check("srq_line_low", {16'h0000, srq_line_low_o}, 17'h00001);
		results();
	end
endmodule // testbench
bind standard_event_status_reporting status_report_props u_props (.clk_sys_i, .rst_i,
	.cmd_i, .evt_i, .srq_o, .srq_oe_o, .rsp_o, .status_byte_o);
